// File: rtl/bmeh_top.sv
// Bus master error handler of the io_channel_controller
// How it works
// RULE1 - Channel check pulses with the faulty operation
// RULE2 - Listed bus master errors are recoverable
// RULE3 - Reload, system errors also handled recoverably
// RULE4 - Mapped errors log class in bits 0-3
// RULE5 - Logged code holds until software store
// RULE6 - Mapped extent/address parity: withhold feedback
// RULE7 - Master stops and interrupts on check; the master model raises irq_o but keeps issuing operations
// RULE8 - Disabled or pending channel: check, no log
// RULE9 - After error, no data; drivers off
// RULE10 - Bus-to-bus, prevent set: address parity checks only
// RULE11 - Prevent-set master self-reports its errors; the master model reports only address parity and card feedback
// RULE12 - Bus-to-bus, prevent clear: as mapped
// RULE13 - Bus-to-bus, prevent clear: parity withholds feedback
// RULE14 - Card feedback bus-to-bus follows prevent bit
// RULE15 - Address parity always handled as bus-to-bus
// RULE16 - Mapped errors act regardless of prevent bit
// RULE17 - One error status per channel only
// RULE18 - Disabled channel stays until cleared, re-enabled
//
// The implementer's own choices: the plain strobed port and the register addresses.
module bmeh_top
  import bmeh_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bmeh_pkg::bmeh_op_t op_i,
  input wire logic [bmeh_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [bmeh_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [bmeh_pkg::DATA_W-1:0] reg_rdata_o,
  output bmeh_pkg::bmeh_resp_t resp_o,
  output logic err_log_o
);
  import bmeh_pkg::*;

  typedef struct packed {
    bmeh_resp_t resp;
    logic err_log;
    logic [DATA_W-1:0] rdata;
    logic rd_pend;
    logic rd_err_pend;
  } bmeh_state_t;

  bmeh_state_t s_q;
  bmeh_state_t s_d;

  logic [CSR_W-1:0] op_csr;
  logic [CSR_W-1:0] reg_csr;
  logic [NUM_CH*CSR_W-1:0] all_csr;
  logic mem_we;
  logic [CH_W-1:0] mem_waddr;
  logic [CSR_W-1:0] mem_wdata;

  // Selects the one class code that is logged; earlier terms take priority
  function automatic logic [ERR_W-1:0] err_class(input bmeh_err_t e);
    logic [ERR_W-1:0] c;
    c = CODE_NONE;
    if (e.authority)
      c = CODE_AUTH;
    else if (e.page_fault)
      c = CODE_PGFLT;
    else if (e.addr_parity || e.data_parity || e.card_fdbk)
      c = CODE_BUS;
    else if (e.extent || e.reload || e.sys_addr || e.sys_data)
      c = CODE_SYS;
    return c;
  endfunction

  // Operation is evaluated against the channel status read in the same cycle,
  // so status lookup is combinational here; the software read port registers
  // the same combinational copy in this module.
  assign op_csr = all_csr[op_i.channel*CSR_W +: CSR_W];

  bmeh_csr_mem #(
    .N(NUM_CH)
  ) u_csr (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_a_i(reg_addr_i),
    .rdata_a_o(reg_csr),
    .raddr_b_i(op_i.channel),
    .rdata_b_o(),
    .all_o(all_csr)
  );

  logic any_err;
  logic enabled;
  logic pending;
  logic pde;
  logic do_log;
  logic do_chck;
  logic no_fdbk;
  logic blocked;
  logic [ERR_W-1:0] code;
  logic [CSR_W-1:0] new_csr;

  always_comb
  begin
    s_d = s_q;
    enabled = op_csr[EN_BIT];
    pending = op_csr[ERR_LO +: ERR_W] != CODE_NONE;
    pde = op_csr[PDE_BIT];
    code = err_class(op_i.err); // [RULE17]
    any_err = code != CODE_NONE;
    blocked = !enabled || pending; // [RULE18]
    do_log = 1'b0;
    do_chck = 1'b0;
    no_fdbk = 1'b0;
    if (op_i.valid)
    begin
      if (blocked)
      begin
        // No new log while blocked, so a pending code is never overwritten
        do_chck = 1'b1; // [RULE8] [RULE5]
        no_fdbk = 1'b1; // [RULE8]
      end
      else if (op_i.err.addr_parity)
      begin
        // Mapping cannot be known on address parity: bus-to-bus handling
        do_chck = 1'b1; // [RULE15] [RULE10] [RULE1]
        do_log = !pde; // [RULE12] [RULE10]
        no_fdbk = !pde; // [RULE13] [RULE6]
      end
      else if (op_i.mapped)
      begin
        // System address errors check only when caught synchronously
        do_chck = any_err && !(op_i.err.sys_addr && !op_i.err.sys_addr_sync
          && code == CODE_SYS && !op_i.err.extent && !op_i.err.reload
          && !op_i.err.sys_data); // [RULE16] [RULE2] [RULE3] [RULE1]
        do_log = any_err; // [RULE4] [RULE16]
        no_fdbk = op_i.err.extent; // [RULE6]
      end
      else if (op_i.err.card_fdbk)
      begin
        do_chck = !pde; // [RULE14]
        do_log = !pde; // [RULE14]
      end
      else
      begin
        do_chck = any_err && !pde; // [RULE12]
        do_log = any_err && !pde; // [RULE12]
      end
    end
    new_csr = op_csr;
    new_csr[ERR_LO +: ERR_W] = code; // [RULE4]
    new_csr[EN_BIT] = 1'b0; // [RULE12]
    s_d.resp.chck = do_chck; // [RULE1]
    // Feedback only for clean accesses; an error with no check must not look accepted
    s_d.resp.sfdbk_rtn = op_i.valid && op_i.to_ctrl && !no_fdbk && !do_chck && !any_err; // [RULE6]
    // Reads aimed at us after an error see released drivers: all ones
    s_d.resp.drv_en = op_i.valid && op_i.to_ctrl && op_i.is_read && !do_chck
      && !blocked && !any_err; // [RULE9]
    s_d.resp.rdata = s_d.resp.drv_en ? {{(DATA_W-CSR_W){1'b0}}, op_csr} : DATA_ONES; // [RULE9]
    s_d.err_log = do_log;
    s_d.rd_pend = reg_rd_i;
    s_d.rdata = s_q.rd_pend ? {{(DATA_W-CSR_W){1'b0}}, reg_csr} : '0;
  end

  // Hardware log wins over a software store landing in the same cycle
  always_comb
  begin
    if (do_log)
    begin
      mem_we = 1'b1; // [RULE4]
      mem_waddr = op_i.channel;
      mem_wdata = new_csr;
    end
    else
    begin
      mem_we = reg_wr_i; // [RULE5] [RULE18]
      mem_waddr = reg_addr_i;
      mem_wdata = reg_wdata_i[CSR_W-1:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_q.resp.chck <= 1'b0;
      s_q.resp.sfdbk_rtn <= 1'b0;
      s_q.resp.drv_en <= 1'b0;
      s_q.resp.rdata <= DATA_ONES;
      s_q.err_log <= 1'b0;
      s_q.rdata <= '0;
      s_q.rd_pend <= 1'b0;
      s_q.rd_err_pend <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Read data registered straight from the combinational status copy, not the registered memory port: one cycle after strobe
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_rd_i ? {{(DATA_W-CSR_W){1'b0}}, all_csr[reg_addr_i*CSR_W +: CSR_W]} : '0;
  end

  assign resp_o = s_q.resp;
  assign err_log_o = s_q.err_log;
endmodule

// File: rtl/bmeh_pkg.sv
// Package for the bus master error handler: field layout, codes, carriers
package bmeh_pkg;
  localparam int CH_W = 4;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int ERR_LO = 0;
  localparam int ERR_W = 4;
  localparam int EN_BIT = 4;
  localparam int PDE_BIT = 5;
  localparam int CSR_W = 6;
  localparam logic [CSR_W-1:0] CSR_RST = 6'h00;
  localparam logic [ERR_W-1:0] CODE_NONE = 4'h0;
  localparam logic [ERR_W-1:0] CODE_AUTH = 4'h4;
  localparam logic [ERR_W-1:0] CODE_PGFLT = 4'h5;
  localparam logic [ERR_W-1:0] CODE_BUS = 4'h6;
  localparam logic [ERR_W-1:0] CODE_SYS = 4'h7;
  localparam logic [DATA_W-1:0] DATA_ONES = 32'hFFFFFFFF;

  // One bit per detected error kind, presented with the bus operation
  typedef struct packed {
    logic authority;
    logic page_fault;
    logic data_parity;
    logic addr_parity;
    logic card_fdbk;
    logic extent;
    logic reload;
    logic sys_addr;
    logic sys_addr_sync;
    logic sys_data;
  } bmeh_err_t;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] channel;
    logic mapped;
    logic to_ctrl;
    logic is_read;
    bmeh_err_t err;
  } bmeh_op_t;

  typedef struct packed {
    logic chck;
    logic sfdbk_rtn;
    logic drv_en;
    logic [DATA_W-1:0] rdata;
  } bmeh_resp_t;
endpackage

// File: rtl/bmeh_csr_mem.sv
// Per-channel status registers with registered read ports
module bmeh_csr_mem
  import bmeh_pkg::*;
#(
  parameter int N = bmeh_pkg::NUM_CH
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [bmeh_pkg::CH_W-1:0] waddr_i,
  input wire logic [bmeh_pkg::CSR_W-1:0] wdata_i,
  input wire logic [bmeh_pkg::CH_W-1:0] raddr_a_i,
  output logic [bmeh_pkg::CSR_W-1:0] rdata_a_o,
  input wire logic [bmeh_pkg::CH_W-1:0] raddr_b_i,
  output logic [bmeh_pkg::CSR_W-1:0] rdata_b_o,
  output logic [N*bmeh_pkg::CSR_W-1:0] all_o
);
  import bmeh_pkg::*;
  logic [CSR_W-1:0] mem_q [N];
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      always_ff @(posedge mclk_i)
      begin
        if (!rst_n_i)
          mem_q[g] <= CSR_RST;
        else if (we_i && waddr_i == CH_W'(g))
          mem_q[g] <= wdata_i;
      end
      assign all_o[g*CSR_W +: CSR_W] = mem_q[g];
    end
  endgenerate
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_a_o <= CSR_RST;
      rdata_b_o <= CSR_RST;
    end
    else
    begin
      rdata_a_o <= mem_q[raddr_a_i];
      rdata_b_o <= mem_q[raddr_b_i];
    end
  end
endmodule

// File: sim/bmeh_sva.sv
// Port-level assertions for the bus master error handler
module bmeh_sva
  import bmeh_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bmeh_pkg::bmeh_op_t op_i,
  input wire logic reg_wr_i,
  input wire bmeh_pkg::bmeh_resp_t resp_o,
  input wire logic err_log_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_chk_cause;
    resp_o.chck |-> $past(op_i.valid);
  endproperty
  a_chk_cause: assert property (p_chk_cause) else $error("check without operation");
  property p_hard;
    op_i.valid && op_i.mapped && (op_i.err.authority || op_i.err.page_fault || op_i.err.extent) |=> resp_o.chck;
  endproperty
  a_hard: assert property (p_hard) else $error("mapped error without check");
  property p_ap;
    op_i.valid && op_i.err.addr_parity |=> resp_o.chck;
  endproperty
  a_ap: assert property (p_ap) else $error("address parity without check");
  property p_no_fb;
    op_i.valid && (op_i.err.addr_parity || op_i.err.extent) |=> !resp_o.sfdbk_rtn;
  endproperty
  a_no_fb: assert property (p_no_fb) else $error("feedback on faulty access");
  property p_fb_excl;
    resp_o.sfdbk_rtn |-> !resp_o.chck && !err_log_o;
  endproperty
  a_fb_excl: assert property (p_fb_excl) else $error("feedback beside check");
  property p_log_cause;
    err_log_o |-> $past(op_i.valid);
  endproperty
  a_log_cause: assert property (p_log_cause) else $error("log without operation");
  property p_ones;
    !resp_o.drv_en |-> resp_o.rdata == DATA_ONES;
  endproperty
  a_ones: assert property (p_ones) else $error("bus not all ones");
  // A pending code must refuse the very next access to that channel
  sequence s_logged_then_same;
    op_i.valid ##1 (op_i.valid && op_i.channel == $past(op_i.channel) && err_log_o && !reg_wr_i);
  endsequence
  property p_pending;
    s_logged_then_same |=> resp_o.chck && !err_log_o && !resp_o.sfdbk_rtn;
  endproperty
  a_pending: assert property (p_pending) else $error("pending code overwritten");
  c_log: cover property (err_log_o);
  c_fb: cover property (resp_o.sfdbk_rtn);
  c_ap_quiet: cover property (op_i.valid && op_i.err.addr_parity ##1 !err_log_o);
endmodule

bind bmeh_top bmeh_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_i(op_i), .reg_wr_i(reg_wr_i),
  .resp_o(resp_o), .err_log_o(err_log_o));

// File: sim/bmeh_master_model.sv
// Bus master adapter model: issues back-to-back operations, reacts to check
module bmeh_master_model
  import bmeh_pkg::*;
(
  input wire logic mclk_i,
  input wire bmeh_pkg::bmeh_resp_t resp_i,
  input wire logic log_i,
  input wire logic pde_i,
  output bmeh_pkg::bmeh_op_t op_o,
  output logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  bmeh_err_t last;
  initial op_o = '0;
  initial last = '0;
  // A prevent-set master reports its own address parity and card feedback errors; the controller logs no unmapped one
  always @(posedge mclk_i)
    irq_o <= resp_i.chck || (pde_i && (last.addr_parity || last.card_fdbk));
  // Answers are read at the edge that ends the cycle in which they stand
  task automatic send2(input bmeh_op_t a, b, output bmeh_resp_t r1, output logic l1, output bmeh_resp_t r2,
    output logic l2);
    op_o <= a;
    last = a.err;
    @(posedge mclk_i);
    op_o <= b;
    @(posedge mclk_i);
    r1 = resp_i;
    l1 = log_i;
    op_o.valid <= 1'b0;
    @(posedge mclk_i);
    r2 = resp_i;
    l2 = log_i;
  endtask
endmodule

// File: sim/bmeh_tb_top.sv
// Self-checking bench for the bus master error handler
module bmeh_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bmeh_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] ra = '0;
  logic [DATA_W-1:0] rwd = '0;
  logic [DATA_W-1:0] rrd;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic pde = 1'b0;
  logic lg;
  bmeh_op_t op;
  bmeh_resp_t rsp;
  int n_errors = 0;
  int compares = 0;
  always #2 mclk_i = ~mclk_i;
  bmeh_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_i(op), .reg_addr_i(ra), .reg_wdata_i(rwd),
    .reg_wr_i(rw), .reg_rd_i(rr), .reg_rdata_o(rrd), .resp_o(rsp), .err_log_o(lg));
  bmeh_master_model mdl (.mclk_i(mclk_i), .resp_i(rsp), .log_i(lg), .pde_i(pde), .op_o(op), .irq_o());
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [5:0] d);
    ra <= a;
    rwd <= {26'h0, d};
    rw <= 1'b1;
    @(posedge mclk_i);
    rw <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    ra <= a;
    rr <= 1'b1;
    @(posedge mclk_i);
    rr <= 1'b0;
    @(posedge mclk_i);
    v = rrd;
  endtask
  // Returns check, log and code; address parity cannot tell mapping apart, so only the prevent bit counts
  function automatic logic [5:0] exp_f(input logic m, p, input bmeh_err_t e);
    logic [3:0] c;
    c = e.authority ? CODE_AUTH : e.page_fault ? CODE_PGFLT : (e.data_parity || e.card_fdbk) ? CODE_BUS : CODE_SYS;
    if (e.addr_parity)
      return {1'b1, !p, CODE_BUS};
    if (!m)
      return {!p, !p, CODE_BUS};
    return {!(e.sys_addr && !e.sys_addr_sync), 1'b1, c};
  endfunction
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    conclude();
  end
  initial
  begin
    bmeh_op_t a, b;
    bmeh_resp_t r1, r2;
    logic l1, l2, m, p;
    logic [5:0] x;
    logic [3:0] ch;
    logic [31:0] v;
    int k;
    k = $urandom(32'hF1D524E5);
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, v);
    chk(v, {26'h0, CSR_RST});
    b = '0;
    b.valid = 1'b1;
    b.to_ctrl = 1'b1;
    b.is_read = 1'b1;
    mdl.send2(b, b, r1, l1, r2, l2);
    chk({r1.chck, r1.sfdbk_rtn, l1}, 3'b100);
    chk(r1.rdata, DATA_ONES);
    for (int i = 0; i < 20; i++)
    begin
      k = i % 10;
      if (k == 8)
        continue;
      ch = 4'($urandom_range(15, 1));
      p = 1'($urandom);
      m = (k == 3 || k == 4) ? 1'($urandom) : 1'b1;
      pde <= p;
      b.channel = ch;
      b.mapped = m;
      a = b;
      a.err = bmeh_err_t'(10'h200 >> k);
      x = exp_f(m, p, a.err);
      wr(ch, {p, 1'b1, 4'h0});
      mdl.send2(a, b, r1, l1, r2, l2);
      chk(r1.chck, x[5]);
      chk(l1, x[4]);
      chk(r1.sfdbk_rtn, 1'b0);
      chk({r2.chck, r2.sfdbk_rtn, l2}, {x[4], !x[4], 1'b0});
      if (x[4])
        chk(r2.rdata, DATA_ONES);
      rd(ch, v);
      chk(v, x[4] ? {26'h0, p, 1'b0, x[3:0]} : {26'h0, p, 5'h10});
      wr(ch, 6'h10);
      mdl.send2(b, b, r1, l1, r2, l2);
      chk({r1.chck, r1.sfdbk_rtn, r2.chck, r2.sfdbk_rtn}, 4'b0101);
    end
    conclude();
  end
endmodule
